/* rtl/rsd_pkg.sv */
// Purpose: constants and types for the reset strap decoder
// Assumes: one 125 MHz clock, synchronous active-low reset
// Notes: strap levels are captured after reset release
//
// Behaviour
// [R1] capture both protocol straps and loader strap at reset
// [R2] loader 1: pairs 00/01/10/11 give i2c/simple uart/uart/spi
// [R3] loader 0: bootloader; 00/10/11 give i2c/uart/spi, 01 reserved
// [R4] spi mode: low protocol strap becomes host wake input after reset
// [R5] clock straps pick crystal, external or internal slow clock
// [R6] first clock strap pulled down; pull released when sampled 1
// [R7] first strap 1: second strap becomes pulled-down input, sampled
// [R8] second strap sampled 1: release its pull-down
// [R9] run from internal, external 32.768 kHz, or 32.768 kHz crystal
// [R10] shared host pins routed by selected protocol
// [R11] address strap is i2c address lsb, or spi serial input
// [R12] host drives select low to address device, high otherwise
// [R13] device drives attention output toward host
// [R14] attention output is active low
// [R15] i2c address 0x4a or 0x4b from address strap
// [R16] strap values held in registers until next reset
package rsd_pkg;
    typedef enum logic [2:0] {
        RSD_IF_I2C, RSD_IF_SUART, RSD_IF_UART, RSD_IF_SPI, RSD_IF_NONE
    } rsd_if_t;
    typedef enum logic [1:0] {
        RSD_CLK_XTAL, RSD_CLK_EXT, RSD_CLK_INT
    } rsd_clk_t;
    typedef struct packed {
        rsd_if_t host_if;
        logic boot_mode;
        logic reserved_sel;
        rsd_clk_t clk_src;
        logic [6:0] i2c_addr;
    } rsd_status_t;
    localparam logic [5:0] I2C_ADDR_HIGH = 6'h25;
    // settle cycles for a pulled strap before it is sampled
    localparam int SETTLE_NS = 1000;
    localparam int CLK_NS = 8;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] SETTLE_W = 8'(SETTLE_CYC);
endpackage : rsd_pkg

/* rtl/rsd_reset_strap_decoder.sv */
// Purpose: capture straps, pick host interface and slow clock, mux pins
// Assumes: pin inputs are asynchronous and pass two flops first
// Notes: protocol engines live outside; this block only steers pins
`timescale 1ns/1ps
module rsd_reset_strap_decoder (
    input wire logic sys_clk, // 125 MHz
    input wire logic reset_in_n, // sync reset, active low
    input wire logic protocol_strap_high, // strap pin
    input wire logic protocol_strap_low_wake, // strap, later wake
    input wire logic loader_select_n, // bootloader strap
    input wire logic clock_strap_first, // clock strap pin in
    input wire logic crystal_out_clock_strap_second, // strap pin in
    input wire logic address_lsb_serial_in, // addr strap / spi in
    input wire logic host_select_n, // spi select, active low
    input wire logic host_pin_a_in, // shared clk/rx pin in
    input wire logic host_pin_b_in, // shared data pin in
    input wire logic eng_pin_b_out, // engine data out value
    input wire logic eng_pin_b_oe, // engine data out enable
    input wire logic eng_attention, // engine needs service
    output logic host_pin_b_out, // shared data pin out
    output logic host_pin_b_oe, // shared data pin enable
    output logic i2c_scl, // routed i2c clock
    output logic i2c_sda, // routed i2c data
    output logic spi_sck, // routed spi clock
    output logic spi_mosi, // routed spi data in
    output logic spi_select_n, // routed spi select
    output logic uart_rx, // routed uart receive
    output logic spi_wake, // synced wake request
    output logic host_attention_n, // attention, active low
    output logic clock_strap_first_pd, // pull-down enable
    output logic clock_strap_second_pd, // pull-down enable
    output logic straps_done, // capture complete
    output rsd_pkg::rsd_status_t status // decoded selection
);
    typedef enum {ST_SETTLE1, ST_SAMPLE1, ST_SETTLE2, ST_SAMPLE2,
        ST_DONE} rsd_st_t;
    rsd_st_t state;
    logic [7:0] cnt;
    logic [7:0] s1;
    logic [7:0] s2;
    logic first_val;
    logic sel_high;
    logic sel_low;
    logic sel_boot;
    rsd_pkg::rsd_if_t sel_if;
    logic [7:0] in_raw;
    logic host_pin_b_s1;
    logic host_pin_b_in_q;
    assign in_raw = {protocol_strap_high, protocol_strap_low_wake,
        loader_select_n, clock_strap_first,
        crystal_out_clock_strap_second, address_lsb_serial_in,
        host_select_n, host_pin_a_in};
    // first stage feeds only the second
    always_ff @(posedge sys_clk) begin
        s1 <= in_raw;
        s2 <= s1;
    end

    function automatic rsd_pkg::rsd_if_t decode_if(logic hi, logic lo,
        logic boot_n);
        if (!boot_n && !hi && lo) begin
            decode_if = rsd_pkg::RSD_IF_NONE; // R3
        end else begin
            case ({hi, lo}) // R2
                2'b00: decode_if = rsd_pkg::RSD_IF_I2C;
                2'b01: decode_if = rsd_pkg::RSD_IF_SUART;
                2'b10: decode_if = rsd_pkg::RSD_IF_UART;
                default: decode_if = rsd_pkg::RSD_IF_SPI;
            endcase
        end
    endfunction : decode_if

    // strap sequence after reset release; pulls settle before sampling
    always_ff @(posedge sys_clk) begin
        if (!reset_in_n) begin
            state <= ST_SETTLE1;
            cnt <= 8'h00;
        end else begin
            case (state)
                ST_SETTLE1: begin
                    cnt <= cnt + 8'h01;
                    if (cnt == rsd_pkg::SETTLE_W) state <= ST_SAMPLE1;
                end
                ST_SAMPLE1: begin
                    cnt <= 8'h00;
                    state <= s2[4] ? ST_SETTLE2 : ST_DONE; // R7
                end
                ST_SETTLE2: begin
                    cnt <= cnt + 8'h01;
                    if (cnt == rsd_pkg::SETTLE_W) state <= ST_SAMPLE2;
                end
                ST_SAMPLE2: state <= ST_DONE;
                ST_DONE: state <= ST_DONE;
                default: state <= ST_SETTLE1;
            endcase
        end
    end

    // protocol and loader straps held until next reset
    always_ff @(posedge sys_clk) begin
        if (!reset_in_n) begin
            sel_high <= 1'b0;
            sel_low <= 1'b0;
            sel_boot <= 1'b1;
            sel_if <= rsd_pkg::RSD_IF_I2C;
            status.host_if <= rsd_pkg::RSD_IF_I2C;
            status.boot_mode <= 1'b0;
            status.reserved_sel <= 1'b0;
            status.i2c_addr <= {rsd_pkg::I2C_ADDR_HIGH, 1'b0};
        end else if (state == ST_SAMPLE1) begin
            sel_high <= s2[7]; // R1 R16
            sel_low <= s2[6]; // R1
            sel_boot <= s2[5]; // R1
            sel_if <= decode_if(s2[7], s2[6], s2[5]);
            status.host_if <= decode_if(s2[7], s2[6], s2[5]);
            status.boot_mode <= !s2[5]; // R3
            status.reserved_sel <= !s2[5] && !s2[7] && s2[6]; // R3
            status.i2c_addr <= {rsd_pkg::I2C_ADDR_HIGH, s2[2]}; // R15 R11
        end
    end

    // slow clock choice and pull-down management
    always_ff @(posedge sys_clk) begin
        if (!reset_in_n) begin
            first_val <= 1'b0;
            status.clk_src <= rsd_pkg::RSD_CLK_XTAL;
            clock_strap_first_pd <= 1'b1; // R6
            clock_strap_second_pd <= 1'b0;
        end else begin
            if (state == ST_SAMPLE1) begin
                first_val <= s2[4];
                if (s2[4]) begin
                    clock_strap_first_pd <= 1'b0; // R6
                    clock_strap_second_pd <= 1'b1; // R7
                end else begin
                    status.clk_src <= rsd_pkg::RSD_CLK_XTAL; // R5 R9
                end
            end
            if (state == ST_SAMPLE2 && first_val) begin
                status.clk_src <= s2[3] ? rsd_pkg::RSD_CLK_EXT
                    : rsd_pkg::RSD_CLK_INT; // R5 R9
                if (s2[3]) clock_strap_second_pd <= 1'b0; // R8
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_in_n) begin
            straps_done <= 1'b0;
        end else begin
            straps_done <= (state == ST_DONE);
        end
    end

    // pin routing; i2c outputs follow pins from reset release, spi, uart, wake and data enable idle until straps are known
    always_ff @(posedge sys_clk) begin
        if (!reset_in_n) begin
            i2c_scl <= 1'b1;
            i2c_sda <= 1'b1;
            spi_sck <= 1'b0;
            spi_mosi <= 1'b0;
            spi_select_n <= 1'b1;
            uart_rx <= 1'b1;
            spi_wake <= 1'b0;
            host_pin_b_out <= 1'b0;
            host_pin_b_oe <= 1'b0;
        end else begin
            i2c_scl <= (sel_if == rsd_pkg::RSD_IF_I2C) ? s2[0] : 1'b1; // R10
            i2c_sda <= (sel_if == rsd_pkg::RSD_IF_I2C) ? host_pin_b_in_q
                : 1'b1;
            spi_sck <= (sel_if == rsd_pkg::RSD_IF_SPI) && s2[0]; // R10
            spi_mosi <= (sel_if == rsd_pkg::RSD_IF_SPI) && s2[2]; // R11
            // host owns select; only passed on in spi mode
            spi_select_n <= (sel_if == rsd_pkg::RSD_IF_SPI) ? s2[1]
                : 1'b1; // R12
            uart_rx <= (sel_if == rsd_pkg::RSD_IF_UART
                || sel_if == rsd_pkg::RSD_IF_SUART) ? s2[0] : 1'b1; // R10
            spi_wake <= (state == ST_DONE) && sel_if == rsd_pkg::RSD_IF_SPI
                && s2[6]; // R4
            // reserved choice drives nothing
            host_pin_b_out <= eng_pin_b_out; // R10
            host_pin_b_oe <= eng_pin_b_oe && (state == ST_DONE)
                && sel_if != rsd_pkg::RSD_IF_NONE; // R10
        end
    end

    // data pin has its own two-flop sync, read only after the second stage
    always_ff @(posedge sys_clk) begin
        host_pin_b_s1 <= host_pin_b_in;
        host_pin_b_in_q <= host_pin_b_s1;
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_in_n) begin
            host_attention_n <= 1'b1; // R14
        end else begin
            host_attention_n <= !(eng_attention && state == ST_DONE); // R13 R14
        end
    end
endmodule : rsd_reset_strap_decoder

/* tb/rsd_reset_strap_decoder_assertions.sv */
// Purpose: assertions on the strap decoder ports
// Assumes: bound to every decoder instance
// Notes: attention may lag its request by one edge
`timescale 1ns/1ps
module rsd_checker (
    input wire logic sys_clk, // clock
    input wire logic reset_in_n, // reset
    input wire logic eng_attention, // request
    input wire logic host_pin_b_oe, // drive
    input wire logic spi_wake, // wake
    input wire logic host_attention_n, // attention
    input wire logic clock_strap_first_pd, // pull
    input wire logic clock_strap_second_pd, // pull
    input wire logic straps_done, // done
    input wire rsd_pkg::rsd_status_t status // result
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_in_n);
    logic xt, it, sp;
    assign xt = status.clk_src == rsd_pkg::RSD_CLK_XTAL;
    assign it = status.clk_src == rsd_pkg::RSD_CLK_INT;
    assign sp = status.host_if == rsd_pkg::RSD_IF_SPI;
    chk_attn_low:
        assert property (eng_attention [*3] |-> !host_attention_n)
        else $error("attention stuck high");
    chk_attn_idle:
        assert property (!eng_attention [*3] |-> host_attention_n)
        else $error("attention stuck low");
    chk_start_pull:
        assert property ($rose(reset_in_n) |-> clock_strap_first_pd && !straps_done)
        else $error("first pull off at start");
    chk_first_pull:
        assert property (straps_done |-> clock_strap_first_pd == xt)
        else $error("first pull wrong");
    chk_second_pull:
        assert property (straps_done |-> clock_strap_second_pd == it)
        else $error("second pull wrong");
    chk_hold_status:
        assert property (straps_done |=> straps_done && $stable(status))
        else $error("selection changed");
    chk_wake_idle:
        assert property (straps_done && !sp |-> !spi_wake)
        else $error("wake outside spi");
    chk_drive_late:
        assert property (!straps_done |-> !host_pin_b_oe)
        else $error("data pin driven early");
    cover property (straps_done && sp);
    cover property (straps_done && status.reserved_sel);
    cover property (straps_done && status.clk_src == rsd_pkg::RSD_CLK_EXT);
endmodule : rsd_checker

bind rsd_reset_strap_decoder rsd_checker u_rsd_checker (.sys_clk(sys_clk),
    .reset_in_n(reset_in_n), .eng_attention(eng_attention), .spi_wake(spi_wake),
    .host_pin_b_oe(host_pin_b_oe), .host_attention_n(host_attention_n),
    .clock_strap_first_pd(clock_strap_first_pd),
    .clock_strap_second_pd(clock_strap_second_pd),
    .straps_done(straps_done), .status(status));

/* tb/rsd_board_model.sv */
// Purpose: board straps and host pins around the decoder
// Assumes: cfg bits 7 and 6 leave the clock straps open
// Notes: cfg low bits are high, low, loader, first, second, address
`timescale 1ns/1ps
module rsd_board_model (
    input wire logic sys_clk, // clock
    input wire logic [7:0] cfg, // strap settings
    input wire logic clock_strap_first_pd, // pull on
    input wire logic clock_strap_second_pd, // pull on
    input wire logic host_pin_b_out, // device data
    input wire logic host_pin_b_oe, // device drive
    output logic protocol_strap_high, // strap
    output logic protocol_strap_low_wake, // strap or wake
    output logic loader_select_n, // strap
    output logic clock_strap_first, // strap
    output logic crystal_out_clock_strap_second, // strap
    output logic address_lsb_serial_in, // strap or data
    output logic host_select_n, // select
    output logic host_pin_a_in, // host clock
    output logic host_pin_b_in // data line
);
    logic [4:0] cnt = 5'h00;
    always_ff @(posedge sys_clk) cnt <= cnt + 5'h01;
    assign {protocol_strap_high, protocol_strap_low_wake} = cfg[5:4];
    assign loader_select_n = cfg[3];
    // unpulled open pin floats, so show a moving level, never a steady one
    assign clock_strap_first = cfg[7] ? ~clock_strap_first_pd & cnt[0]
        : cfg[2];
    assign crystal_out_clock_strap_second = cfg[6]
        ? ~clock_strap_second_pd & cnt[0] : cfg[1];
    assign address_lsb_serial_in = cfg[0];
    assign host_pin_a_in = cnt[3];
    assign host_select_n = cnt[4];
    assign host_pin_b_in = host_pin_b_oe ? host_pin_b_out : 1'b1;
endmodule : rsd_board_model

/* tb/tb_rsd_reset_strap_decoder.sv */
// Purpose: self-checking bench for the strap decoder
// Assumes: board model supplies straps and host pins
// Notes: every case restarts the design with new straps
`timescale 1ns/1ps
module tb_rsd_reset_strap_decoder;
    logic sys_clk = 1'b0;
    logic reset_in_n = 1'b0;
    logic eng_attention = 1'b0;
    logic [7:0] strap = 8'h88;
    logic protocol_strap_high, protocol_strap_low_wake, loader_select_n;
    logic clock_strap_first, crystal_out_clock_strap_second, host_pin_b_in;
    logic address_lsb_serial_in, host_select_n, host_pin_a_in, spi_wake;
    logic host_pin_b_out, host_pin_b_oe, i2c_scl, spi_sck, spi_mosi, uart_rx;
    logic host_attention_n, clock_strap_first_pd, clock_strap_second_pd;
    logic straps_done, i2c_sda, spi_select_n;
    rsd_pkg::rsd_status_t status;
    int miscompares = 0;
    int total_checks = 0;
    int cyc = 0;
    always #4 sys_clk = ~sys_clk;
    rsd_board_model u_rsd_board_model (.sys_clk, .cfg(strap),
        .protocol_strap_high, .protocol_strap_low_wake, .loader_select_n,
        .clock_strap_first, .crystal_out_clock_strap_second,
        .address_lsb_serial_in, .host_select_n, .host_pin_a_in,
        .host_pin_b_in, .clock_strap_first_pd, .clock_strap_second_pd,
        .host_pin_b_out, .host_pin_b_oe);
    rsd_reset_strap_decoder u_rsd_reset_strap_decoder (.sys_clk, .reset_in_n,
        .protocol_strap_high, .protocol_strap_low_wake, .loader_select_n,
        .clock_strap_first, .crystal_out_clock_strap_second,
        .address_lsb_serial_in, .host_select_n, .host_pin_a_in,
        .host_pin_b_in, .eng_pin_b_out(1'b0), .eng_pin_b_oe(1'b1),
        .eng_attention, .host_pin_b_out, .host_pin_b_oe, .i2c_scl,
        .i2c_sda, .spi_sck, .spi_mosi, .spi_select_n, .uart_rx,
        .spi_wake, .host_attention_n, .clock_strap_first_pd,
        .clock_strap_second_pd, .straps_done, .status);
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            final_report();
        end
    end
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : cmp
    task automatic boot(input logic [7:0] s);
        int n;
        n = 0;
        strap <= s;
        reset_in_n <= 1'b0;
        repeat (20) @(posedge sys_clk);
        reset_in_n <= 1'b1;
        while (straps_done !== 1'b1 && n < 400) begin
            @(posedge sys_clk);
            n++;
        end
        cmp({7'h0, straps_done}, 8'h01);
        repeat (4) @(posedge sys_clk);
    endtask : boot
    // routes lag the pin by three edges, so compare against a held copy
    task automatic route(input logic [2:0] m);
        logic v;
        logic w;
        v = host_pin_a_in;
        w = host_select_n;
        repeat (3) @(posedge sys_clk);
        case (m)
            3'h0: begin
                cmp({7'h0, i2c_scl}, {7'h0, v});
                cmp({7'h0, i2c_sda}, 8'h00);
            end
            3'h1, 3'h2: begin
                cmp({7'h0, uart_rx}, {7'h0, v});
                cmp({7'h0, i2c_sda}, 8'h01);
            end
            3'h3: begin
                cmp({7'h0, spi_sck}, {7'h0, v});
                cmp({7'h0, spi_select_n}, {7'h0, w});
            end
            default: cmp({7'h0, host_pin_b_oe}, 8'h00);
        endcase
        if (m != 3'h4) cmp({7'h0, host_pin_b_oe}, 8'h01);
    endtask : route
    task automatic t_modes(input logic ldr);
        for (int p = 0; p < 4; p++) begin
            boot({2'b10, 2'(p), ldr, 2'b00, ldr});
            cmp(8'(status.host_if), (!ldr && p == 1) ? 8'h04 : 8'(p));
            cmp({7'h0, status.boot_mode}, {7'h0, !ldr});
            cmp({7'h0, status.reserved_sel}, {7'h0, !ldr && p == 1});
            cmp(8'(status.clk_src), 8'h00);
            if (p == 0) cmp({1'b0, status.i2c_addr}, {7'h25, ldr});
            route((!ldr && p == 1) ? 3'h4 : 3'(p));
        end
        $display("test modes done, loader %0d", ldr);
    endtask : t_modes
    task automatic t_clock;
        logic [7:0] cfg [3] = '{8'h08, 8'h0e, 8'h4c};
        for (int k = 0; k < 3; k++) begin
            boot(cfg[k]);
            cmp(8'(status.clk_src), 8'(k));
            cmp({7'h0, clock_strap_first_pd}, {7'h0, k == 0});
            cmp({7'h0, clock_strap_second_pd}, {7'h0, k == 2});
        end
        $display("test clock done");
    endtask : t_clock
    task automatic t_spi;
        boot(8'hb9);
        strap <= 8'h88;
        repeat (5) @(posedge sys_clk);
        cmp({6'h0, spi_wake, spi_mosi}, 8'h00);
        cmp(8'(status.host_if), 8'h03);
        strap <= 8'h99;
        repeat (5) @(posedge sys_clk);
        cmp({6'h0, spi_wake, spi_mosi}, 8'h03);
        eng_attention <= 1'b1;
        repeat (3) @(posedge sys_clk);
        cmp({7'h0, host_attention_n}, 8'h00);
        eng_attention <= 1'b0;
        repeat (3) @(posedge sys_clk);
        cmp({7'h0, host_attention_n}, 8'h01);
        $display("test spi and attention done");
    endtask : t_spi
    initial begin
        t_modes(1'b1);
        t_modes(1'b0);
        t_clock();
        t_spi();
        final_report();
    end
endmodule : tb_rsd_reset_strap_decoder
